// file: bench/i2c_bus_partner.sv
/*
  Far side of the serial bus: one master making START, a byte and STOP.
  Assumes pull-ups on both lines; its tasks are called by the bench.
*/
`timescale 1ns/1ps

module i2c_bus_partner (
  output logic scl_out,
  output logic sda_out
);
  localparam int HALF_NS = 40;
  localparam int QTR_NS = 20;

  // ==========================================================
  // idle: both lines released, pull-ups hold them high, clock still
  initial begin
    scl_out = 1'h1;
    sda_out = 1'h1;
  end

  // data falls while clock high, then clock parks low
  task automatic start_cond();
    sda_out = 1'h0;
    #(HALF_NS);
    scl_out = 1'h0;
    #(HALF_NS);
  endtask

  // one 80 ns clock period, data moved a quarter period after the fall
  task automatic clk_pulse(input logic d);
    #(QTR_NS);
    sda_out = d;
    #(HALF_NS - QTR_NS);
    scl_out = 1'h1;
    #(HALF_NS);
    scl_out = 1'h0;
  endtask

  // msb first, data changes only while clock low
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      clk_pulse(b[i]);
    end
    clk_pulse(1'h1); // released for the acknowledge slot
  endtask

  // data rises while clock high, bus free afterwards
  task automatic stop_cond();
    #(QTR_NS);
    sda_out = 1'h0;
    #(HALF_NS);
    scl_out = 1'h1;
    #(HALF_NS);
    sda_out = 1'h1;
    #(HALF_NS);
  endtask
endmodule

// file: bench/i2c_status_flags_properties.sv
/*
  Checker of the status flag block: register port answers and transmit hand-off.
  Assumes binding to the block below; it sees that block's ports only.
*/
`timescale 1ns/1ps
`include "i2c_status_defs.svh"

module i2c_status_flags_properties (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic [2:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [15:0] rd_data_out,
  input wire logic tx_load_req_in,
  input wire logic [7:0] tx_byte_out,
  input wire logic tx_byte_valid_out,
  input wire logic module_run_out,
  input wire logic loopback_out,
  input wire logic forced_noack_out
);
  // ==========================================================
  // accepted strobes, last byte written for transmission
  logic take_rd;
  logic take_wr;
  logic take_txreq;
  logic [2:0] wr_low;
  logic [7:0] tx_last_r;
  assign take_rd = rd_en_in && clk_en_in;
  assign take_wr = wr_en_in && clk_en_in;
  assign take_txreq = tx_load_req_in && clk_en_in;
  assign wr_low = wr_data_in[2:0];
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_last_r <= 8'h00;
    end else if (take_wr && addr_in == `OFS_TX_DATA) begin
      tx_last_r <= wr_data_in[7:0];
    end
  end

  // ==========================================================
  // properties
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  chk_reserved_zero: assert property (rd_data_out[`BIT_RESERVED15] == 1'h0)
    else $error("reserved status bit read as one");
  chk_read_quiet: assert property (!take_rd |=> rd_data_out == 16'h0000)
    else $error("read data outside its answer cycle");
  chk_unmapped_zero: assert property (take_rd && addr_in[2:1] == 2'h3 |=> rd_data_out == 16'h0000)
    else $error("unmapped offset read nonzero");
  chk_rx_upper: assert property (take_rd && addr_in == `OFS_RX_DATA |=> rd_data_out[15:8] == 8'h00)
    else $error("receive data upper byte nonzero");
  chk_mode_write: assert property (take_wr && addr_in == `OFS_MODE_CTRL |=>
      {forced_noack_out, loopback_out, module_run_out} == $past(wr_low))
    else $error("mode bits differ from written value");
  chk_mode_hold: assert property (!(take_wr && addr_in == `OFS_MODE_CTRL) |=>
      $stable({forced_noack_out, loopback_out, module_run_out}))
    else $error("mode bits changed without a write");
  chk_idle_status: assert property (take_rd && addr_in == `OFS_BUS_STATUS && !module_run_out
      && !$past(module_run_out) |=> rd_data_out == `BUS_STATUS_RESET)
    else $error("status not at reset value while held in reset");
  chk_tx_cause: assert property (tx_byte_valid_out |-> $past(take_txreq))
    else $error("transmit byte handed over without a request");
  chk_tx_byte: assert property (tx_byte_valid_out |-> tx_byte_out == tx_last_r)
    else $error("transmit byte differs from last written");
endmodule

bind i2c_status_flags i2c_status_flags_properties i_chk (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
  .rd_data_out(rd_data_out), .tx_load_req_in(tx_load_req_in), .tx_byte_out(tx_byte_out),
  .tx_byte_valid_out(tx_byte_valid_out), .module_run_out(module_run_out),
  .loopback_out(loopback_out), .forced_noack_out(forced_noack_out)
);

// file: bench/i2c_status_flags_tb.sv
/*
  Bench for the status flag block: register traffic, flag events, bus conditions.
  Assumes the partner model and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
`include "i2c_status_defs.svh"

module i2c_status_flags_tb;
  logic clk_sys_in, reset_n_in, wr_en_in, rd_en_in, scl, sda, addressed_as_slave_flag, tx_valid, irq, rd_seen;
  logic [2:0] addr_in;
  logic [15:0] wr_data_in, rd_data_out, st;
  logic [6:0] ev;
  logic [7:0] rx_byte, tx_byte, rx0, rx1;
  logic [15:0] rd_q[$];
  logic [7:0] tx_q[$];
  int n_mismatch, checks, seed;
  int w1c[5] = '{`BIT_SLAVE_DIR, `BIT_RECEIVED_FLAG_A_SENT, `BIT_ACCESS_READY, `BIT_RECEIVED_FLAG_A_RCVD, `BIT_ARB_LOST};

  // ==========================================================
  // design and far side
  i2c_status_flags i_i2c_status_flags (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .clk_en_in(1'h1),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .scl_in(scl), .sda_in(sda), .slave_tx_addr_in(ev[4]),
    .received_flag_a_driven_in(ev[3]), .received_flag_a_rcvd_in(ev[1]), .arb_lost_in(ev[0]),
    .access_ready_in(ev[2]), .addressed_as_slave_in(addressed_as_slave_flag), .zero_address_in(addressed_as_slave_flag),
    .rx_byte_valid_in(ev[5]), .rx_byte_in(rx_byte), .tx_load_req_in(ev[6]),
    .tx_byte_out(tx_byte), .tx_byte_valid_out(tx_valid), .module_run_out(),
    .loopback_out(), .forced_noack_out(), .irq_out(irq)
  );
  i2c_bus_partner i_i2c_bus_partner (.scl_out(scl), .sda_out(sda));

  initial begin
    clk_sys_in = 1'h0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  // ==========================================================
  // compare, verdict, bus tasks
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic req = 1'h0);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'h1;
    ev[6] <= req;
    @(posedge clk_sys_in);
    wr_en_in <= 1'h0;
    ev[6] <= 1'h0;
    @(posedge clk_sys_in);
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    addr_in <= a;
    rd_en_in <= 1'h1;
    @(posedge clk_sys_in);
    rd_en_in <= 1'h0;
    @(posedge clk_sys_in);
  endtask

  task automatic rs(input logic [15:0] e);
    rd(`OFS_BUS_STATUS, e);
  endtask

  task automatic pulse(input logic [6:0] m);
    ev <= m;
    @(posedge clk_sys_in);
    ev <= 7'h00;
    @(posedge clk_sys_in);
  endtask

  task automatic wait_irq(input logic v);
    @(negedge clk_sys_in);
    for (int i = 0; i < 8 && irq !== v; i++) @(negedge clk_sys_in);
    cmp({15'h0000, irq}, {15'h0000, v});
    @(posedge clk_sys_in);
  endtask

  task automatic settle();
    repeat (8) @(posedge clk_sys_in);
  endtask

  // ==========================================================
  // oldest note against each read answer and each handed-over byte
  always @(posedge clk_sys_in) rd_seen <= rd_en_in;
  always @(negedge clk_sys_in) begin
    if (rd_seen === 1'h1) cmp(rd_data_out, rd_q.pop_front());
    // an unannounced byte meets FFFF, which an 8-bit value never matches
    if (tx_valid === 1'h1) cmp({8'h00, tx_byte}, tx_q.size() ? {8'h00, tx_q.pop_front()} : 16'hFFFF);
  end

  initial begin
    for (int i = 0; i < 40000; i++) @(posedge clk_sys_in);
    n_mismatch++;
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 93284;
    reset_n_in = 1'h0;
    addr_in = 3'h0;
    wr_data_in = 16'h0000;
    wr_en_in = 1'h0;
    rd_en_in = 1'h0;
    ev = 7'h00;
    addressed_as_slave_flag = 1'h0;
    rx_byte = 8'h00;
    repeat (12) @(posedge clk_sys_in);
    reset_n_in <= 1'h1;
    @(posedge clk_sys_in);
    // reset values, unmapped offsets, read-only flags
    rs(`BUS_STATUS_RESET);
    rd(`OFS_MODE_CTRL, 16'h0000);
    rd(3'h6, 16'h0000);
    rd(3'h7, 16'h0000);
    wr(`OFS_MODE_CTRL, 16'h0001);
    addressed_as_slave_flag <= 1'h1;
    wr(`OFS_BUS_STATUS, 16'hFFFF);
    rs(16'h0710);
    addressed_as_slave_flag <= 1'h0;
    // event flags, interrupt masking, clears one bit at a time
    pulse(7'h1F);
    rs(16'h6417);
    wr(`OFS_BUS_STATUS, 16'h0000);
    rs(16'h6417);
    rd(`OFS_IRQ_STATUS, 16'h0030);
    wait_irq(1'h0);
    rd(`OFS_IRQ_STATUS, 16'h0000);
    wr(`OFS_IRQ_MASK, 16'h0020);
    rd(`OFS_IRQ_MASK, 16'h0020);
    pulse(7'h01);
    wait_irq(1'h1);
    rd(`OFS_IRQ_STATUS, 16'h0020);
    wait_irq(1'h0);
    st = 16'h6417;
    foreach (w1c[i]) begin
      wr(`OFS_BUS_STATUS, 16'h0001 << w1c[i]);
      st = st & ~(16'h0001 << w1c[i]);
      rs(st);
    end
    // bus conditions from the far side, then loopback
    pulse(7'h10);
    i_i2c_bus_partner.start_cond();
    settle();
    rs(16'h1410);
    i_i2c_bus_partner.send_byte(8'($random(seed)));
    i_i2c_bus_partner.stop_cond();
    settle();
    rs(16'h0430);
    rd(`OFS_IRQ_STATUS, 16'h0003);
    wr(`OFS_BUS_STATUS, 16'h0020);
    pulse(7'h10);
    wr(`OFS_MODE_CTRL, 16'h0003);
    rs(16'h0410);
    wr(`OFS_MODE_CTRL, 16'h0005);
    // receive with overrun
    rx0 = 8'($random(seed));
    rx1 = 8'($random(seed));
    rx_byte <= rx0;
    pulse(7'h20);
    rx_byte <= rx1;
    pulse(7'h20);
    rs(16'h0C18);
    rd(`OFS_RX_DATA, {8'h00, rx0});
    rs(16'h0418);
    rd(`OFS_RX_DATA, {8'h00, rx1});
    wr(`OFS_BUS_STATUS, 16'h0008);
    rs(16'h0410);
    rd(`OFS_IRQ_STATUS, 16'h0004);
    // transmit, underflow, write beside a request
    rx0 = 8'($random(seed));
    tx_q.push_back(rx0);
    wr(`OFS_TX_DATA, {8'h00, rx0});
    rs(16'h0400);
    pulse(7'h40);
    rs(16'h0410);
    pulse(7'h40);
    rs(16'h0010);
    rd(`OFS_IRQ_STATUS, 16'h0008);
    rx0 = 8'($random(seed));
    tx_q.push_back(rx0);
    wr(`OFS_TX_DATA, {8'h00, rx0}, 1'h1);
    rs(16'h0410);
    // module reset during a busy bus
    pulse(7'h08);
    i_i2c_bus_partner.start_cond();
    settle();
    rs(16'h3410);
    wr(`OFS_MODE_CTRL, 16'h0000);
    rs(`BUS_STATUS_RESET);
    wr(`OFS_MODE_CTRL, 16'h0001);
    i_i2c_bus_partner.stop_cond();
    settle();
    rs(16'h0430);
    // second reset in mid-run
    reset_n_in <= 1'h0;
    repeat (2) @(posedge clk_sys_in);
    reset_n_in <= 1'h1;
    @(posedge clk_sys_in);
    rs(`BUS_STATUS_RESET);
    rd(`OFS_IRQ_MASK, 16'h0000);
    cmp(16'(rd_q.size() + tx_q.size()), 16'h0000);
    complete_run();
  end
endmodule

// file: verilog/i2c_bus_cond.sv
/*
  START and STOP condition detector on synchronised clock and data levels.
  Assumes inputs already passed two flip-flops.
*/
`timescale 1ns/1ps

module i2c_bus_cond (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic start_out,
  output logic stop_out
);

  i2c_status_pkg::cond_state_t st_r;
  i2c_status_pkg::cond_state_t st_nxt;

  // ==========================================================
  // data edge while clock high marks a condition
  always_comb begin
    st_nxt = st_r;
    st_nxt.scl_prev = scl_in;
    st_nxt.sda_prev = sda_in;
    st_nxt.start = st_r.scl_prev && scl_in && st_r.sda_prev && !sda_in;
    st_nxt.stop = st_r.scl_prev && scl_in && !st_r.sda_prev && sda_in;
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= 4'hC;
    end else if (clk_en_in) begin
      st_r <= st_nxt;
    end
  end

  assign start_out = st_r.start;
  assign stop_out = st_r.stop;

endmodule

// file: verilog/i2c_pin_sync.sv
/*
  Two-stage synchroniser for the serial clock and data pins.
  Assumes the pins are asynchronous to clk_sys_in.
*/
`timescale 1ns/1ps

module i2c_pin_sync (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic [1:0] pins_in,
  output logic [1:0] pins_out
);

  i2c_status_pkg::sync_state_t st_r;
  i2c_status_pkg::sync_state_t st_nxt;

  // ==========================================================
  // two flops per pin, first stage read only by the second
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < 2; i++) begin
      st_nxt.stage1[i] = pins_in[i];
      st_nxt.stage2[i] = st_r.stage1[i];
    end
  end

  // state register, idle bus is high
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= 4'hF;
    end else if (clk_en_in) begin
      st_r <= st_nxt;
    end
  end

  assign pins_out = st_r.stage2;

endmodule

// file: verilog/i2c_status_defs.svh
/*
  Register offsets, bit positions, reset values and widths for the I2C status flag block.
  Assumes inclusion by bare name; holds definitions only.
*/
`ifndef I2C_STATUS_DEFS_SVH
`define I2C_STATUS_DEFS_SVH

// ==========================================================
// register word offsets
`define OFS_BUS_STATUS 3'h0
`define OFS_MODE_CTRL 3'h1
`define OFS_RX_DATA 3'h2
`define OFS_TX_DATA 3'h3
`define OFS_IRQ_STATUS 3'h4
`define OFS_IRQ_MASK 3'h5

// ==========================================================
// bus_status bit positions
`define BIT_RESERVED15 15
`define BIT_SLAVE_DIR 14
`define BIT_RECEIVED_FLAG_A_SENT 13
`define BIT_BUS_BUSY 12
`define BIT_RX_OVERRUN 11
`define BIT_TX_SHIFT 10
`define BIT_ADDR_SLAVE 9
`define BIT_ZERO_ADDR 8
`define BIT_STOP_DET 5
`define BIT_TX_READY 4
`define BIT_RX_READY 3
`define BIT_ACCESS_READY 2
`define BIT_RECEIVED_FLAG_A_RCVD 1
`define BIT_ARB_LOST 0

// ==========================================================
// bus_status reset value and write-one-to-clear mask
`define BUS_STATUS_RESET 16'h0410
`define BUS_STATUS_W1C 16'h602F

// ==========================================================
// mode_control_register bits and reset value
`define BIT_MODULE_RUN 0
`define BIT_LOOPBACK 1
`define BIT_FORCED_NOACK 2
`define MODE_CTRL_RESET 3'h0

// ==========================================================
// interrupt status / mask bit positions
`define IRQ_START 0
`define IRQ_STOP 1
`define IRQ_OVERRUN 2
`define IRQ_UNDERFLOW 3
`define IRQ_RECEIVED_FLAG_A_SENT 4
`define IRQ_ARB_LOST 5
`define IRQ_W 6

`endif

// file: verilog/i2c_status_flags.sv
/*
  Status flag logic of an I2C controller: the 16-bit bus_status register, mode control,
  receive and transmit data holding, and a sticky interrupt status with mask.
  Assumes event inputs come from the controller's shift logic on clk_sys_in, one-cycle
  pulses; scl_in and sda_in are raw bus pin levels.
*/
// The implementer's own choices: the address-and-strobe port and the address map.
// Function
// - one 16-bit status register shows interrupt causes and bus and transfer state.
// - bit 15 always reads zero and writes to it do nothing.
// - the seven write-one-to-clear flags clear on a written 1 and ignore a written 0.
// - reset leaves bits 10 and 4 at 1 and all others at 0; six flags are read-only.
// - the slave direction flag sets when addressed as a slave transmitter.
// - it clears on a written 1, on loopback enabled, or on START or STOP.
// - the RECEIVED_FLAG_A sent flag sets when a no-acknowledge is driven as receiver.
// - it clears on a written 1, on module run bit written 0, or on device reset.
// - bit 12 shows whether the bus is occupied or free.
// - bus busy sets on START and clears on STOP or module reset.
// - overrun sets when a byte arrives unread, the copy waits, and a read clears it.
// - the transmit shift flag drops on underflow and sets on a data write or reset.
`timescale 1ns/1ps
`include "i2c_status_defs.svh"

module i2c_status_flags (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic [2:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [15:0] rd_data_out,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic slave_tx_addr_in,
  input wire logic received_flag_a_driven_in,
  input wire logic received_flag_a_rcvd_in,
  input wire logic arb_lost_in,
  input wire logic access_ready_in,
  input wire logic addressed_as_slave_in,
  input wire logic zero_address_in,
  input wire logic rx_byte_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic tx_load_req_in,
  output logic [7:0] tx_byte_out,
  output logic tx_byte_valid_out,
  output logic module_run_out,
  output logic loopback_out,
  output logic forced_noack_out,
  output logic irq_out
);

  i2c_status_pkg::top_state_t st_r;
  i2c_status_pkg::top_state_t st_nxt;

  logic [1:0] pins_sync;
  logic bus_start;
  logic bus_stop;

  // ==========================================================
  // address decode used by both strobes
  function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
    hit = (a == ofs);
  endfunction

  // ==========================================================
  // pin synchroniser and condition detector
  i2c_pin_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .pins_in({scl_in, sda_in}),
    .pins_out(pins_sync)
  );

  i2c_bus_cond u_cond (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .scl_in(pins_sync[1]),
    .sda_in(pins_sync[0]),
    .start_out(bus_start),
    .stop_out(bus_stop)
  );

  // ==========================================================
  // next-state logic
  always_comb begin
    logic wr_status;
    logic wr_mode;
    logic wr_tx;
    logic wr_irq_mask;
    logic rd_rx;
    logic rd_irq;
    logic run;
    logic [15:0] w1c;
    logic [`IRQ_W-1:0] irq_set;
    logic underflow;
    logic overrun_evt;
    wr_status = wr_en_in && hit(addr_in, `OFS_BUS_STATUS);
    wr_mode = wr_en_in && hit(addr_in, `OFS_MODE_CTRL);
    wr_tx = wr_en_in && hit(addr_in, `OFS_TX_DATA);
    wr_irq_mask = wr_en_in && hit(addr_in, `OFS_IRQ_MASK);
    rd_rx = rd_en_in && hit(addr_in, `OFS_RX_DATA);
    rd_irq = rd_en_in && hit(addr_in, `OFS_IRQ_STATUS);
    run = st_r.mode[`BIT_MODULE_RUN];
    irq_set = '0;
    underflow = 1'b0;
    overrun_evt = 1'b0;
    // write-one-to-clear only where the mask allows
    w1c = wr_status ? (wr_data_in & `BUS_STATUS_W1C) : 16'h0000;
    st_nxt = st_r;
    st_nxt.tx_valid = 1'b0;

    // mode control register
    if (wr_mode) begin
      st_nxt.mode = wr_data_in[2:0];
    end

    // interrupt mask register
    if (wr_irq_mask) begin
      st_nxt.irq_mask = wr_data_in[`IRQ_W-1:0];
    end

    // clear of write-one-to-clear flags, applied before the sets below
    st_nxt.status = st_r.status & ~w1c;

    // slave direction: clear on loopback or bus condition, set wins over a bus condition or a written 1, not over loopback
    if (st_r.mode[`BIT_LOOPBACK] || bus_start || bus_stop) begin
      st_nxt.status[`BIT_SLAVE_DIR] = 1'b0;
    end
    if (slave_tx_addr_in && !st_r.mode[`BIT_LOOPBACK]) begin
      st_nxt.status[`BIT_SLAVE_DIR] = 1'b1;
    end

    // received_flag_a sent while receiving, incl. forced no-acknowledge
    if (received_flag_a_driven_in) begin
      st_nxt.status[`BIT_RECEIVED_FLAG_A_SENT] = 1'b1;
      irq_set[`IRQ_RECEIVED_FLAG_A_SENT] = 1'b1;
    end

    // bus busy follows START and STOP
    if (bus_stop) begin
      st_nxt.status[`BIT_BUS_BUSY] = 1'b0;
    end
    if (bus_start) begin
      st_nxt.status[`BIT_BUS_BUSY] = 1'b1;
    end

    // stop detected, other wire events
    if (bus_stop) begin
      st_nxt.status[`BIT_STOP_DET] = 1'b1;
    end
    if (received_flag_a_rcvd_in) begin
      st_nxt.status[`BIT_RECEIVED_FLAG_A_RCVD] = 1'b1;
    end
    if (arb_lost_in) begin
      st_nxt.status[`BIT_ARB_LOST] = 1'b1;
      irq_set[`IRQ_ARB_LOST] = 1'b1;
    end
    if (access_ready_in) begin
      st_nxt.status[`BIT_ACCESS_READY] = 1'b1;
    end
    irq_set[`IRQ_START] = bus_start;
    irq_set[`IRQ_STOP] = bus_stop;

    // read-only level flags from the address matcher
    st_nxt.status[`BIT_ADDR_SLAVE] = addressed_as_slave_in;
    st_nxt.status[`BIT_ZERO_ADDR] = zero_address_in;

    // ==========================================================
    // receive path: a read frees the register and takes the held byte
    if (rd_rx) begin
      st_nxt.rx_full = 1'b0;
      st_nxt.status[`BIT_RX_READY] = 1'b0;
      st_nxt.status[`BIT_RX_OVERRUN] = 1'b0;
      if (st_r.rx_pend_v) begin
        st_nxt.rx_data = st_r.rx_pend;
        st_nxt.rx_full = 1'b1;
        st_nxt.rx_pend_v = 1'b0;
        st_nxt.status[`BIT_RX_READY] = 1'b1;
      end
    end
    if (rx_byte_valid_in) begin
      if (st_nxt.rx_full) begin
        // unread data still there: hold new byte and flag overrun
        st_nxt.rx_pend = rx_byte_in;
        st_nxt.rx_pend_v = 1'b1;
        st_nxt.status[`BIT_RX_OVERRUN] = 1'b1;
        overrun_evt = 1'b1;
      end else begin
        st_nxt.rx_data = rx_byte_in;
        st_nxt.rx_full = 1'b1;
        st_nxt.status[`BIT_RX_READY] = 1'b1;
      end
    end
    irq_set[`IRQ_OVERRUN] = overrun_evt;

    // ==========================================================
    // transmit path: shift register asks, holding register answers
    if (tx_load_req_in) begin
      if (st_r.tx_loaded) begin
        st_nxt.tx_byte = st_r.tx_data;
        st_nxt.tx_valid = 1'b1;
        st_nxt.tx_loaded = 1'b0;
        st_nxt.status[`BIT_TX_READY] = 1'b1;
      end else begin
        // nothing new: old byte may go out again
        st_nxt.status[`BIT_TX_SHIFT] = 1'b0;
        underflow = 1'b1;
      end
    end
    if (wr_tx) begin
      st_nxt.tx_data = wr_data_in[7:0];
      st_nxt.tx_loaded = 1'b1;
      st_nxt.status[`BIT_TX_READY] = 1'b0;
      st_nxt.status[`BIT_TX_SHIFT] = 1'b1;
      // a write in the same cycle as a request with no byte loaded is forwarded at once
      if (tx_load_req_in && !st_r.tx_loaded) begin
        st_nxt.tx_byte = wr_data_in[7:0];
        st_nxt.tx_valid = 1'b1;
        st_nxt.tx_loaded = 1'b0;
        st_nxt.status[`BIT_TX_READY] = 1'b1;
        underflow = 1'b0;
      end
    end
    irq_set[`IRQ_UNDERFLOW] = underflow;

    // ==========================================================
    // module held in reset while the run bit is 0
    if (!run) begin
      st_nxt.status = `BUS_STATUS_RESET;
      st_nxt.rx_full = 1'b0;
      st_nxt.rx_pend_v = 1'b0;
      st_nxt.tx_loaded = 1'b0;
      st_nxt.tx_valid = 1'b0;
      irq_set = '0;
    end

    // reserved bit stays zero
    st_nxt.status[`BIT_RESERVED15] = 1'b0;

    // ==========================================================
    // sticky interrupt status: read clears, a new event wins
    if (rd_irq) begin
      st_nxt.irq_stat = irq_set;
    end else begin
      st_nxt.irq_stat = st_r.irq_stat | irq_set;
    end
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);

    // ==========================================================
    // read data, valid only in the cycle after the strobe
    st_nxt.rd_data = 16'h0000;
    if (rd_en_in) begin
      case (addr_in)
        `OFS_BUS_STATUS: st_nxt.rd_data = st_r.status;
        `OFS_MODE_CTRL: st_nxt.rd_data = {13'h0000, st_r.mode};
        `OFS_RX_DATA: st_nxt.rd_data = {8'h00, st_r.rx_data};
        `OFS_TX_DATA: st_nxt.rd_data = {8'h00, st_r.tx_data};
        `OFS_IRQ_STATUS: st_nxt.rd_data = {10'h000, st_r.irq_stat};
        `OFS_IRQ_MASK: st_nxt.rd_data = {10'h000, st_r.irq_mask};
        default: st_nxt.rd_data = 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // state register, frozen while clock enable is low
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= '0;
      st_r.status <= `BUS_STATUS_RESET;
      st_r.mode <= `MODE_CTRL_RESET;
    end else if (clk_en_in) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign rd_data_out = st_r.rd_data;
  assign tx_byte_out = st_r.tx_byte;
  assign tx_byte_valid_out = st_r.tx_valid;
  assign module_run_out = st_r.mode[`BIT_MODULE_RUN];
  assign loopback_out = st_r.mode[`BIT_LOOPBACK];
  assign forced_noack_out = st_r.mode[`BIT_FORCED_NOACK];
  assign irq_out = st_r.irq;

endmodule

// file: verilog/i2c_status_pkg.sv
/*
  Types shared by the I2C status flag block and its helpers.
  Assumes i2c_status_defs.svh is available on the include path.
*/
`include "i2c_status_defs.svh"

package i2c_status_pkg;

  // ==========================================================
  // pin synchroniser state
  typedef struct packed {
    logic [1:0] stage1;
    logic [1:0] stage2;
  } sync_state_t;

  // ==========================================================
  // start/stop detector state
  typedef struct packed {
    logic scl_prev;
    logic sda_prev;
    logic start;
    logic stop;
  } cond_state_t;

  // ==========================================================
  // status block state
  typedef struct packed {
    logic [2:0] mode;
    logic [15:0] status;
    logic [7:0] rx_data;
    logic rx_full;
    logic [7:0] rx_pend;
    logic rx_pend_v;
    logic [7:0] tx_data;
    logic tx_loaded;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic [`IRQ_W-1:0] irq_stat;
    logic [`IRQ_W-1:0] irq_mask;
    logic irq;
    logic [15:0] rd_data;
  } top_state_t;

endpackage
